// ### verilog/tco_pkg.sv
// Register map, field layout and fixed counter limits of the timer output control.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package tco_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL_A = 8'h80;
	localparam logic [7:0] OFS_CTRL_HI = 8'h84;
	localparam logic [7:0] OFS_CMP_A = 8'h88;
	localparam logic [7:0] OFS_CMP_B = 8'h8C;
	localparam logic [7:0] OFS_CAPT = 8'h90;
	localparam logic [7:0] OFS_CNT = 8'h94;
	localparam logic [7:0] OFS_STS = 8'h98;
	localparam logic [7:0] OFS_CLR = 8'h9C;
	localparam logic [7:0] OFS_IEN = 8'hA0;
	localparam logic [7:0] OFS_PIN = 8'hA4;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTL_COMA_LSB = 6;
	localparam int CTL_COMB_LSB = 4;
	localparam int CTL_WGM_LSB = 0;
	localparam int HI_WGM_LSB = 0;
	localparam int PIN_DIR_LSB = 0;
	localparam int PIN_DAT_LSB = 2;
	localparam int STS_OVF = 0;
	localparam int STS_CMA = 1;
	localparam int STS_CMB = 2;

	// ****************************************************************
	// Counter limits, output modes, bus answers
	// ****************************************************************
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8 = 16'h00FF;
	localparam logic [15:0] TOP_9 = 16'h01FF;
	localparam logic [15:0] TOP_10 = 16'h03FF;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TGL = 2'h1;
	localparam logic [1:0] COM_CLR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		KIND_NORM = 2'b00,
		KIND_FAST = 2'b01,
		KIND_DUAL = 2'b10
	} tco_kind_t;

endpackage : tco_pkg

// ### verilog/tco_timer_output.sv
// 16-bit timer with two compare channels and waveform pin control.
// Assumes count_tick is a one-cycle enable from a prescaler on aclk.
`timescale 1ns/1ps
module tco_timer_output
	import tco_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic count_tick,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic chan_a_wave_pin_in,
	output logic chan_a_wave_pin_level,
	output logic chan_a_wave_pin_drive,
	input wire logic chan_b_wave_pin_in,
	output logic chan_b_wave_pin_level,
	output logic chan_b_wave_pin_drive,
	output logic irq
);

	if (CNT_W != 16) begin : g_bad_width
		$error("CNT_W must be 16");
	end

	typedef struct packed {
		logic [1:0][1:0] com;
		logic [3:0] wgm;
		logic [1:0][CNT_W-1:0] cbuf;
		logic [1:0][CNT_W-1:0] cmp;
		logic [CNT_W-1:0] capt;
		logic [CNT_W-1:0] cnt;
		logic down;
		logic [1:0] wave;
		logic [2:0] sts;
		logic [2:0] ien;
		logic [1:0] dir;
		logic [1:0] pdat;
		logic [1:0] ps1;
		logic [1:0] ps2;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} tco_state_t;

	tco_state_t st_ff;
	tco_state_t nxt_st;
	tco_kind_t kind;
	logic [CNT_W-1:0] top;
	logic pfc;
	logic at_top;
	logic at_bot;
	logic upd;
	logic wr_go;
	logic rd_go;
	logic [2:0] ev;
	logic [2:0] clr;
	logic [1:0] match;
	logic [1:0] tgl_ok;
	logic [1:0] conn;
	logic [1:0] pin_lvl;

	function automatic logic [CNT_W-1:0] wr16(
		input logic [CNT_W-1:0] old,
		input logic [31:0] d,
		input logic [3:0] s
	);
		wr16 = old;
		if (s[0]) wr16[7:0] = d[7:0];
		if (s[1]) wr16[15:8] = d[15:8];
	endfunction : wr16

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	always_comb begin
		unique case (st_ff.wgm)
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: kind = KIND_FAST;
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: kind = KIND_DUAL;
			default: kind = KIND_NORM;
		endcase
	end

	always_comb begin
		unique case (st_ff.wgm)
			4'h1, 4'h5: top = TOP_8;
			4'h2, 4'h6: top = TOP_9;
			4'h3, 4'h7: top = TOP_10;
			4'h4, 4'h9, 4'hB, 4'hF: top = st_ff.cmp[0];
			4'h8, 4'hA, 4'hC, 4'hE: top = st_ff.capt;
			default: top = TOP_MAX;
		endcase
	end

	assign pfc = (st_ff.wgm == 4'h8) || (st_ff.wgm == 4'h9);
	assign at_top = (st_ff.cnt == top);
	assign at_bot = (st_ff.cnt == BOTTOM);
	assign upd = count_tick && ((kind == KIND_FAST && at_top) ||
		(kind == KIND_DUAL && (pfc ? (at_bot && st_ff.down) : (at_top && !st_ff.down))));

	// ****************************************************************
	// Per-channel match and pin connection
	// ****************************************************************
	for (genvar g = 0; g < 2; g++) begin : g_ch
		assign match[g] = count_tick && (st_ff.cnt == st_ff.cmp[g]);
		if (g == 0) begin : g_a
			assign tgl_ok[g] = (kind == KIND_FAST && st_ff.wgm[3:1] == 3'b111) ||
				(kind == KIND_DUAL && st_ff.wgm[3:2] == 2'b10);
		end else begin : g_b
			assign tgl_ok[g] = 1'b0;
		end
		assign conn[g] = (st_ff.com[g] != COM_OFF) &&
			(st_ff.com[g] != COM_TGL || kind == KIND_NORM || tgl_ok[g]);
		assign pin_lvl[g] = conn[g] ? st_ff.wave[g] : st_ff.pdat[g];
	end

	// ****************************************************************
	// Bus handshakes
	// ****************************************************************
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_ff.bvalid;
	assign rd_go = s_axi_arvalid && !st_ff.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		ev = 3'h0;
		clr = 3'h0;
		nxt_st.ps1 = {chan_b_wave_pin_in, chan_a_wave_pin_in};
		nxt_st.ps2 = st_ff.ps1;
		if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;
		if (st_ff.rvalid && s_axi_rready) nxt_st.rvalid = 1'b0;
		if (wr_go) begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = RESP_OKAY;
			unique case (s_axi_awaddr)
				OFS_CTRL_A: if (s_axi_wstrb[0]) begin
					nxt_st.com[0] = s_axi_wdata[CTL_COMA_LSB +: 2];
					nxt_st.com[1] = s_axi_wdata[CTL_COMB_LSB +: 2];
					nxt_st.wgm[1:0] = s_axi_wdata[CTL_WGM_LSB +: 2];
				end
				OFS_CTRL_HI: if (s_axi_wstrb[0]) begin
					nxt_st.wgm[3:2] = s_axi_wdata[HI_WGM_LSB +: 2];
				end
				OFS_CMP_A: nxt_st.cbuf[0] = wr16(st_ff.cbuf[0], s_axi_wdata, s_axi_wstrb);
				OFS_CMP_B: nxt_st.cbuf[1] = wr16(st_ff.cbuf[1], s_axi_wdata, s_axi_wstrb);
				OFS_CAPT: nxt_st.capt = wr16(st_ff.capt, s_axi_wdata, s_axi_wstrb);
				OFS_CNT, OFS_STS: begin
				end
				OFS_CLR: if (s_axi_wstrb[0]) begin
					clr = s_axi_wdata[2:0];
				end
				OFS_IEN: if (s_axi_wstrb[0]) begin
					nxt_st.ien = s_axi_wdata[2:0];
				end
				OFS_PIN: if (s_axi_wstrb[0]) begin
					nxt_st.dir = s_axi_wdata[PIN_DIR_LSB +: 2];
					nxt_st.pdat = s_axi_wdata[PIN_DAT_LSB +: 2];
				end
				default: nxt_st.bresp = RESP_SLVERR;
			endcase
		end
		if (rd_go) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = RESP_OKAY;
			nxt_st.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				OFS_CTRL_A: nxt_st.rdata = 32'({st_ff.com[0], st_ff.com[1], 2'b00,
					st_ff.wgm[1:0]});
				OFS_CTRL_HI: nxt_st.rdata = 32'(st_ff.wgm[3:2]);
				OFS_CMP_A: nxt_st.rdata = 32'(st_ff.cbuf[0]);
				OFS_CMP_B: nxt_st.rdata = 32'(st_ff.cbuf[1]);
				OFS_CAPT: nxt_st.rdata = 32'(st_ff.capt);
				OFS_CNT: nxt_st.rdata = 32'(st_ff.cnt);
				OFS_STS: nxt_st.rdata = 32'(st_ff.sts);
				OFS_CLR: nxt_st.rdata = 32'h0000_0000;
				OFS_IEN: nxt_st.rdata = 32'(st_ff.ien);
				OFS_PIN: nxt_st.rdata = 32'({st_ff.ps2, st_ff.pdat, st_ff.dir});
				default: nxt_st.rresp = RESP_SLVERR;
			endcase
		end

		// Counter
		if (count_tick) begin
			unique case (kind)
				KIND_DUAL: begin
					if (!st_ff.down) begin
						if (!at_top) begin
							nxt_st.cnt = st_ff.cnt + 1'b1;
						end else if (top != BOTTOM) begin
							nxt_st.down = 1'b1;
							nxt_st.cnt = st_ff.cnt - 1'b1;
						end
					end else if (at_bot) begin
						nxt_st.down = 1'b0;
						if (top != BOTTOM) nxt_st.cnt = st_ff.cnt + 1'b1;
					end else begin
						nxt_st.cnt = st_ff.cnt - 1'b1;
					end
					ev[STS_OVF] = at_bot && st_ff.down;
				end
				KIND_FAST: begin
					nxt_st.down = 1'b0;
					nxt_st.cnt = at_top ? BOTTOM : st_ff.cnt + 1'b1;
					ev[STS_OVF] = at_top;
				end
				default: begin
					nxt_st.down = 1'b0;
					nxt_st.cnt = at_top ? BOTTOM : st_ff.cnt + 1'b1;
					ev[STS_OVF] = (st_ff.cnt == TOP_MAX);
				end
			endcase
		end
		ev[STS_CMA] = match[0];
		ev[STS_CMB] = match[1];
		nxt_st.sts = (st_ff.sts & ~clr) | ev;

		// Compare buffers and waveforms
		for (int c = 0; c < 2; c++) begin
			if (upd) nxt_st.cmp[c] = st_ff.cbuf[c];
			if (kind == KIND_NORM) nxt_st.cmp[c] = nxt_st.cbuf[c];
			if (st_ff.com[c] == COM_TGL) begin
				if (match[c] && (kind == KIND_NORM || tgl_ok[c])) begin
					nxt_st.wave[c] = ~st_ff.wave[c];
				end
			end else if (st_ff.com[c][1]) begin
				unique case (kind)
					KIND_FAST: begin
						if (count_tick && at_top) begin
							nxt_st.wave[c] = ~st_ff.com[c][0];
						end else if (match[c] && st_ff.cmp[c] != top) begin
							nxt_st.wave[c] = st_ff.com[c][0];
						end
					end
					KIND_DUAL: if (match[c]) begin
						nxt_st.wave[c] = st_ff.down ^ st_ff.com[c][0];
					end
					default: if (match[c]) begin
						nxt_st.wave[c] = st_ff.com[c][0];
					end
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rresp = st_ff.rresp;
	assign s_axi_rdata = st_ff.rdata;
	assign chan_a_wave_pin_level = pin_lvl[0];
	assign chan_b_wave_pin_level = pin_lvl[1];
	assign chan_a_wave_pin_drive = st_ff.dir[0];
	assign chan_b_wave_pin_drive = st_ff.dir[1];
	assign irq = |(st_ff.sts & st_ff.ien);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_pfc_bottom_load: assert property (
		pfc && count_tick && st_ff.down && at_bot |=> st_ff.cmp[0] == $past(st_ff.cbuf[0]))
		else $error("compare not loaded at bottom");
	chk_pfc_top_hold: assert property (
		pfc && count_tick && !st_ff.down && at_top |=> $stable(st_ff.cmp[0]))
		else $error("compare loaded at top");
	chk_pin_a_mux: assert property (
		conn[0] |-> chan_a_wave_pin_level == st_ff.wave[0])
		else $error("channel a waveform not on pin");
	chk_pin_b_mux: assert property (
		conn[1] |-> chan_b_wave_pin_level == st_ff.wave[1])
		else $error("channel b waveform not on pin");
	chk_drive_dir: assert property (
		wr_go && s_axi_awaddr == OFS_PIN && s_axi_wstrb[0]
		|=> chan_a_wave_pin_drive == $past(s_axi_wdata[PIN_DIR_LSB]))
		else $error("pin driver not following direction");
	chk_norm_set: assert property (
		kind == KIND_NORM && st_ff.com[0] == COM_SET && match[0] |=> st_ff.wave[0])
		else $error("set on match missing");
	chk_fast_b_tgl: assert property (
		kind == KIND_FAST && st_ff.com[1] == COM_TGL |-> !conn[1])
		else $error("channel b toggle connected in fast mode");
	chk_fast_top_set: assert property (
		kind == KIND_FAST && st_ff.com[0] == COM_CLR && count_tick && at_top |=> st_ff.wave[0])
		else $error("output not set at top");
	chk_fast_top_clr: assert property (
		kind == KIND_FAST && st_ff.com[0] == COM_SET && count_tick && at_top |=> !st_ff.wave[0])
		else $error("output not cleared at top");
	chk_dual_up_clr: assert property (
		kind == KIND_DUAL && st_ff.com[0] == COM_CLR && match[0] && !st_ff.down
		|=> !st_ff.wave[0])
		else $error("output not cleared on up match");
	chk_norm_wrap: assert property (
		st_ff.wgm == 4'h0 && count_tick && st_ff.cnt == TOP_MAX
		|=> st_ff.cnt == BOTTOM && st_ff.sts[STS_OVF])
		else $error("normal mode wrap wrong");
	chk_pc8_turn: assert property (
		st_ff.wgm == 4'h1 && count_tick && !st_ff.down && st_ff.cnt == TOP_8
		|=> st_ff.down && st_ff.cnt == $past(st_ff.cnt) - 16'h0001)
		else $error("8-bit dual slope does not turn at top");
	chk_dual_bottom: assert property (
		kind == KIND_DUAL && count_tick && st_ff.down && at_bot && top != BOTTOM
		|=> !st_ff.down && st_ff.cnt == 16'h0001 && st_ff.sts[STS_OVF])
		else $error("dual slope does not turn at bottom");

endmodule : tco_timer_output

// ### bench/test_tco_timer_output.sv
// Testbench for the timer output control: registers, pin modes, interrupt, overflow.
// Assumes bus answers within a few cycles; pin outputs loop back to pin inputs.
`timescale 1ns/1ps
module test_tco_timer_output
	import tco_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} tco_reg_row_t;
	typedef struct {logic [1:0] ca; logic [1:0] cb; logic ea; logic eb;} tco_pin_row_t;

	// ****************************************************************
	// Signals, cases and design
	// ****************************************************************
	logic aclk, aresetn, count_tick, irq;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, got;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic pa, pa_en, pb, pb_en;
	int n_fail = 0;
	int compares = 0;
	tco_reg_row_t regs [5] = '{
		'{OFS_CTRL_A, 32'h000000FF, 32'h000000F3, RESP_OKAY},
		'{OFS_CTRL_HI, 32'h000000FF, 32'h00000003, RESP_OKAY},
		'{OFS_CMP_A, 32'h00012345, 32'h00002345, RESP_OKAY},
		'{OFS_CLR, 32'h00000007, 32'h00000000, RESP_OKAY},
		'{8'h40, 32'hFFFFFFFF, 32'h00000000, RESP_SLVERR}
	};
	tco_pin_row_t prow [5] = '{
		'{COM_TGL, COM_SET, 1'b1, 1'b1},
		'{COM_TGL, COM_CLR, 1'b0, 1'b0},
		'{COM_CLR, COM_SET, 1'b0, 1'b1},
		'{COM_SET, COM_TGL, 1'b1, 1'b0},
		'{COM_OFF, COM_OFF, 1'b0, 1'b1}
	};

	tco_timer_output i_tco_timer_output (
		.aclk(aclk), .aresetn(aresetn), .count_tick(count_tick),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.chan_a_wave_pin_in(pa), .chan_a_wave_pin_level(pa), .chan_a_wave_pin_drive(pa_en),
		.chan_b_wave_pin_in(pb), .chan_b_wave_pin_level(pb), .chan_b_wave_pin_drive(pb_en),
		.irq(irq)
	);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic finish_test;
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] val);
		compares++;
		if (val !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, val);
		end
	endtask : chk

	task automatic chk1(input string what, input logic exp, input logic val);
		chk(what, {31'h0, exp}, {31'h0, val});
	endtask : chk1

	task automatic pins(input logic ea, input logic eb);
		chk1("pin a level", ea, pa);
		chk1("pin b level", eb, pb);
	endtask : pins

	task automatic tmo(input int k);
		if (k >= 100) begin
			n_fail++;
			$display("unexpected bus wait: expected answer, seen none");
			finish_test();
		end
	endtask : tmo

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
		end while (!(awready === 1'b1 && wready === 1'b1) && k < 50);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do begin
			@(posedge aclk);
			k++;
		end while (bvalid !== 1'b1 && k < 100);
		resp = bresp;
		#1;
		tmo(k);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int k;
		k = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
		end while (arready !== 1'b1 && k < 50);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			k++;
		end while (rvalid !== 1'b1 && k < 100);
		got = rdata;
		resp = rresp;
		#1;
		tmo(k);
	endtask : rd

	task automatic step(input int n);
		@(posedge aclk);
		count_tick <= 1'b1;
		repeat (n) @(posedge aclk);
		count_tick <= 1'b0;
		#1;
	endtask : step

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		aresetn = 1'b0;
		count_tick = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hF;
		bready = 1'b1;
		rready = 1'b1;
		repeat (5) @(posedge aclk);
		chk1("pin a drive", 1'b0, pa_en);
		chk1("irq", 1'b0, irq);
		aresetn <= 1'b1;
		rd(OFS_CTRL_A);
		chk("reset control", 32'h00000000, got);
		$display("reset test done");
		foreach (regs[i]) begin
			wr(regs[i].a, regs[i].d);
			chk("bresp", {30'h0, regs[i].r}, {30'h0, resp});
			rd(regs[i].a);
			chk("rdata", regs[i].q, got);
			chk("rresp", {30'h0, regs[i].r}, {30'h0, resp});
		end
		$display("register test done");
		wr(OFS_PIN, 32'h00000008);
		chk1("pin a drive", 1'b0, pa_en);
		chk1("pin b drive", 1'b0, pb_en);
		wr(OFS_PIN, 32'h0000000B);
		chk1("pin a drive", 1'b1, pa_en);
		chk1("pin b drive", 1'b1, pb_en);
		wr(OFS_CMP_A, 32'h00000003);
		wr(OFS_CMP_B, 32'h00000001);
		wr(OFS_CTRL_HI, 32'h00000001);
		foreach (prow[i]) begin
			wr(OFS_CTRL_A, {24'h0, prow[i].ca, prow[i].cb, 4'h0});
			step(4);
			pins(prow[i].ea, prow[i].eb);
		end
		rd(OFS_PIN);
		chk("pin readback", 32'h0000002B, got);
		$display("compare mode test done");
		wr(OFS_IEN, 32'h00000002);
		chk1("irq", 1'b1, irq);
		wr(OFS_CLR, 32'h00000007);
		chk1("irq", 1'b0, irq);
		step(4);
		rd(OFS_STS);
		chk("status", 32'h00000006, got);
		chk1("irq", 1'b1, irq);
		wr(OFS_IEN, 32'h00000000);
		chk1("irq", 1'b0, irq);
		$display("interrupt test done");
		wr(OFS_CMP_A, 32'h00000007);
		wr(OFS_CTRL_A, 32'h000000B3);
		wr(OFS_CTRL_HI, 32'h00000003);
		step(2);
		pins(1'b1, 1'b1);
		step(6);
		pins(1'b1, 1'b0);
		wr(OFS_CTRL_A, 32'h000000E3);
		step(8);
		pins(1'b0, 1'b1);
		wr(OFS_CTRL_A, 32'h000000B3);
		step(8);
		pins(1'b1, 1'b0);
		$display("fast pwm test done");
		wr(OFS_CTRL_A, 32'h00000073);
		wr(OFS_CTRL_HI, 32'h00000002);
		step(2);
		pins(1'b1, 1'b1);
		step(11);
		pins(1'b0, 1'b1);
		step(1);
		pins(1'b0, 1'b0);
		$display("dual slope test done");
		wr(OFS_PIN, 32'h0000000F);
		wr(OFS_CTRL_A, 32'h00000051);
		wr(OFS_CTRL_HI, 32'h00000001);
		pins(1'b1, 1'b1);
		wr(OFS_CTRL_HI, 32'h00000000);
		pins(1'b1, 1'b1);
		$display("disconnect test done");
		wr(OFS_CLR, 32'h00000007);
		step(1);
		rd(OFS_STS);
		chk("overflow", 32'h00000001, {31'h0, got[STS_OVF]});
		wr(OFS_CLR, 32'h00000001);
		step(509);
		rd(OFS_STS);
		chk("overflow", 32'h00000000, {31'h0, got[STS_OVF]});
		step(1);
		rd(OFS_STS);
		chk("overflow", 32'h00000001, {31'h0, got[STS_OVF]});
		$display("overflow test done");
		wr(OFS_CAPT, 32'h0000000A);
		wr(OFS_CTRL_HI, 32'h00000002);
		wr(OFS_CTRL_A, 32'h000000B0);
		wr(OFS_CMP_A, 32'h00000003);
		step(13);
		pins(1'b1, 1'b1);
		step(6);
		pins(1'b1, 1'b0);
		step(4);
		pins(1'b0, 1'b1);
		$display("phase and frequency correct test done");
		wr(OFS_CTRL_HI, 32'h00000000);
		wr(OFS_CLR, 32'h00000007);
		step(65531);
		rd(OFS_CNT);
		chk("counter", 32'h0000FFFF, got);
		step(1);
		rd(OFS_STS);
		chk("overflow", 32'h00000001, {31'h0, got[STS_OVF]});
		rd(OFS_CNT);
		chk("counter", 32'h00000000, got);
		$display("normal wrap test done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		chk1("pin a drive", 1'b0, pa_en);
		chk1("pin b level", 1'b0, pb);
		chk1("irq", 1'b0, irq);
		rd(OFS_STS);
		chk("reset status", 32'h00000000, got);
		$display("second reset test done");
		finish_test();
	end

endmodule : test_tco_timer_output
